// File: src/slcr_top.sv
/*
 * Second loop configuration bank: Avalon-MM slave with waitrequest,
 * register storage and decoded loop control outputs.
 * Assumes one 25 MHz clock, synchronous active-high reset, and a master
 * that holds its request until waitrequest is sampled low.
 */
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "slcr_map.svh"
// Operation
// R1: Doubler bit 0: 0 enables, 1 bypasses
// R2: Reference setpoint: low byte plus nibble
// R3: Reference divide 1..4095, zero acts one
// R4: Feedback setpoint sixteen bits, two bytes
// R5: Pump current four bits, sixteen steps
// R6: Detector up, down enables and polarity
// R7: Force bits drive pump up or down
// R8: Software never sets both force bits
// R9: Path bits select divide 1,2,4,8
// R10: Path bit 0 enables divider path
// R11: Driver standard bits and driver enable
// R12: Driver CML termination selection bits
// R13: Software writes zeros to reserved bits
module slcr_top (
    // Clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_sys_rst,
    // Avalon-MM slave
    input  wire logic [7:0]               i_avs_address,
    input  wire logic                     i_avs_read,
    input  wire logic                     i_avs_write,
    input  wire logic [31:0]              i_avs_writedata,
    input  wire logic [3:0]               i_avs_byteenable,
    output logic [31:0]                   o_avs_readdata,
    output logic                          o_avs_waitrequest,
    // Reference path
    output logic                          o_doubler_bypass,
    output logic [11:0]                   o_loop2_ref_divider,
    output logic [15:0]                   o_loop2_feedback_divider,
    // Pump and detector
    output logic [3:0]                    o_pump_current_setting,
    output logic                          o_detector_up_enable,
    output logic                          o_detector_down_enable,
    output logic                          o_pump_force_up,
    output logic                          o_pump_force_down,
    output logic                          o_detector_polarity,
    // Oscillator output path
    output logic                          o_osc_path_enable,
    output slcr_pkg::slcr_div_e           o_osc_out_divide_ratio,
    output logic [3:0]                    o_osc_div_factor,
    // Oscillator drivers
    output slcr_pkg::slcr_std_e           o_osc_driver_standard_0,
    output slcr_pkg::slcr_term_e          o_osc_driver_term_0,
    output logic                          o_osc_driver_enable_0,
    output slcr_pkg::slcr_std_e           o_osc_driver_standard_1,
    output slcr_pkg::slcr_term_e          o_osc_driver_term_1,
    output logic                          o_osc_driver_enable_1
);
    import slcr_pkg::*;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    slcr_state_e   state_q;
    slcr_state_e   state_d;
    logic          wait_q;
    logic [3:0]    idx_w;
    logic          in_range_w;
    logic          req_w;
    logic          take_w;
    logic          lane0_w;
    logic [`SLCR_NUM_REGS*8-1:0] regs_w;

    slcr_mem_if mp ();

    // Byte address is four times the register index
    assign in_range_w = (i_avs_address[7:2] >= 6'(`SLCR_IDX_FIRST))
                     && (i_avs_address[7:2] <  6'(`SLCR_IDX_FIRST + `SLCR_NUM_REGS))
                     && (i_avs_address[1:0] == 2'h0);
    assign idx_w      = in_range_w ? 4'(i_avs_address[7:2] - `SLCR_IDX_FIRST) : 4'hF;
    assign req_w      = i_avs_read || i_avs_write;
    assign take_w     = req_w && state_q == SLCR_ST_IDLE;
    assign lane0_w    = i_avs_byteenable[0];

    assign mp.idx     = idx_w;
    assign mp.wdata   = i_avs_writedata[7:0];
    // Write lands at the edge where the master sees waitrequest low
    assign mp.we      = i_avs_write && state_q == SLCR_ST_ACK && in_range_w && lane0_w;

    slcr_regfile u_regfile (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .mp        (mp),
        .o_regs    (regs_w)
    );

    // ------------------------------------------------------------------
    // Bus handshake: IDLE sees a request, ACK drops waitrequest for one cycle
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            SLCR_ST_IDLE: if (take_w) state_d = SLCR_ST_ACK;
            SLCR_ST_ACK:  state_d = SLCR_ST_IDLE;
            default:      state_d = SLCR_ST_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_q <= SLCR_ST_IDLE;
            wait_q  <= 1'b1;
        end else begin
            state_q <= state_d;
            wait_q  <= (state_d != SLCR_ST_ACK);
        end
    end

    // Both bus outputs come from flip-flops; the store reads zero when unmapped
    assign o_avs_waitrequest = wait_q;
    assign o_avs_readdata    = {24'h000000, mp.rdata};

    // ------------------------------------------------------------------
    // Decoded controls, each from a flip-flop
    // ------------------------------------------------------------------
    function automatic slcr_byte_t reg_at(input logic [`SLCR_NUM_REGS*8-1:0] v,
                                          input logic [7:0] off);
        return v[(off - `SLCR_IDX_FIRST)*8 +: 8];
    endfunction : reg_at

    slcr_byte_t r_dbl_w, r_rlo_w, r_rhi_w, r_flo_w, r_fhi_w;
    slcr_byte_t r_pump_w, r_det_w, r_path_w, r_drv0_w, r_drv1_w;
    logic [11:0] ref_raw_w;
    logic [3:0]  div_factor_w;

    assign r_dbl_w  = reg_at(regs_w, `SLCR_IDX_DOUBLER);
    assign r_rlo_w  = reg_at(regs_w, `SLCR_IDX_REF_LO);
    assign r_rhi_w  = reg_at(regs_w, `SLCR_IDX_REF_HI);
    assign r_flo_w  = reg_at(regs_w, `SLCR_IDX_FB_LO);
    assign r_fhi_w  = reg_at(regs_w, `SLCR_IDX_FB_HI);
    assign r_pump_w = reg_at(regs_w, `SLCR_IDX_PUMP);
    assign r_det_w  = reg_at(regs_w, `SLCR_IDX_DETECT);
    assign r_path_w = reg_at(regs_w, `SLCR_IDX_OSC_PATH);
    assign r_drv0_w = reg_at(regs_w, `SLCR_IDX_DRV0);
    assign r_drv1_w = reg_at(regs_w, `SLCR_IDX_DRV1);

    assign ref_raw_w = {r_rhi_w[`SLCR_REF_HI_MSB:0], r_rlo_w}; // R2
    assign div_factor_w = 4'(4'h1 << r_path_w[`SLCR_PATH_DIV_MSB:`SLCR_PATH_DIV_LSB]); // R9

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            o_doubler_bypass         <= 1'b0;
            o_loop2_ref_divider      <= 12'h001;
            o_loop2_feedback_divider <= 16'h0000;
            o_pump_current_setting   <= 4'h0;
            o_detector_up_enable     <= 1'b0;
            o_detector_down_enable   <= 1'b0;
            o_pump_force_up          <= 1'b0;
            o_pump_force_down        <= 1'b0;
            o_detector_polarity      <= 1'b0;
            o_osc_path_enable        <= 1'b0;
            o_osc_out_divide_ratio   <= SLCR_DIV_1;
            o_osc_div_factor         <= 4'h1;
            o_osc_driver_standard_0  <= SLCR_STD_CML;
            o_osc_driver_term_0      <= SLCR_TERM_OFF;
            o_osc_driver_enable_0    <= 1'b0;
            o_osc_driver_standard_1  <= SLCR_STD_CML;
            o_osc_driver_term_1      <= SLCR_TERM_OFF;
            o_osc_driver_enable_1    <= 1'b0;
        end else begin
            o_doubler_bypass         <= r_dbl_w[`SLCR_DBL_BYPASS_BIT]; // R1
            o_loop2_ref_divider      <= (ref_raw_w == 12'h000) ? 12'h001 : ref_raw_w; // R3
            o_loop2_feedback_divider <= {r_fhi_w, r_flo_w}; // R4
            o_pump_current_setting   <= r_pump_w[`SLCR_PUMP_MSB:0]; // R5
            o_detector_up_enable     <= r_det_w[`SLCR_DET_UP_EN_BIT]; // R6
            o_detector_down_enable   <= r_det_w[`SLCR_DET_DN_EN_BIT]; // R6
            o_detector_polarity      <= r_det_w[`SLCR_DET_POL_BIT]; // R6
            o_pump_force_up          <= r_det_w[`SLCR_DET_FUP_BIT]; // R7
            o_pump_force_down        <= r_det_w[`SLCR_DET_FDN_BIT]; // R7
            o_osc_path_enable        <= r_path_w[`SLCR_PATH_EN_BIT]; // R10
            o_osc_out_divide_ratio   <= slcr_div_e'(r_path_w[2:1]); // R9
            o_osc_div_factor         <= div_factor_w; // R9
            o_osc_driver_standard_0  <= slcr_std_e'(r_drv0_w[5:4]); // R11
            o_osc_driver_enable_0    <= r_drv0_w[`SLCR_DRV_EN_BIT]; // R11
            o_osc_driver_term_0      <= slcr_term_e'(r_drv0_w[2:1]); // R12
            o_osc_driver_standard_1  <= slcr_std_e'(r_drv1_w[5:4]); // R11
            o_osc_driver_enable_1    <= r_drv1_w[`SLCR_DRV_EN_BIT]; // R11
            o_osc_driver_term_1      <= slcr_term_e'(r_drv1_w[2:1]); // R12
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_doubler;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        1 |=> o_doubler_bypass == $past(r_dbl_w[0]);
    endproperty
    a_doubler: assert property (p_doubler) else $error("doubler bypass mismatch"); // R1

    property p_ref_join;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (ref_raw_w != 12'h000) |=> o_loop2_ref_divider == {$past(r_rhi_w[3:0]), $past(r_rlo_w)};
    endproperty
    a_ref_join: assert property (p_ref_join) else $error("reference setpoint mismatch"); // R2

    property p_ref_zero;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (ref_raw_w == 12'h000) |=> o_loop2_ref_divider == 12'h001;
    endproperty
    a_ref_zero: assert property (p_ref_zero) else $error("zero setpoint not one"); // R3

    property p_fb;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        1 |=> o_loop2_feedback_divider == {$past(r_fhi_w), $past(r_flo_w)};
    endproperty
    a_fb: assert property (p_fb) else $error("feedback setpoint mismatch"); // R4

    property p_pump;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (mp.we && idx_w == 4'h6) |=> ##1 o_pump_current_setting == $past(mp.wdata[3:0], 2);
    endproperty
    a_pump: assert property (p_pump) else $error("pump current not updated"); // R5

    property p_det;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (mp.we && idx_w == 4'h7) |=> ##1
            {o_detector_up_enable, o_detector_down_enable, o_pump_force_up,
             o_pump_force_down, o_detector_polarity} == $past(mp.wdata[4:0], 2);
    endproperty
    a_det: assert property (p_det) else $error("detector controls not updated"); // R6

    property p_div;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        1 |-> o_osc_div_factor == 4'(4'h1 << o_osc_out_divide_ratio);
    endproperty
    a_div: assert property (p_div) else $error("divide factor mismatch"); // R9

    property p_drv;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (mp.we && idx_w == 4'h9) |=> ##1
            {o_osc_driver_standard_0, o_osc_driver_term_0, o_osc_driver_enable_0}
            == {$past(mp.wdata[5:4], 2), $past(mp.wdata[2:0], 2)};
    endproperty
    a_drv: assert property (p_drv) else $error("driver 0 controls not updated"); // R11

    property p_ack;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take_w) |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
    endproperty
    a_ack: assert property (p_ack) else $error("waitrequest not one cycle low");

    property p_wait_idle;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (o_avs_waitrequest && !take_w) |=> o_avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest fell unasked");

    property p_rd_unmapped;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take_w && i_avs_read && !in_range_w) |=> o_avs_readdata == `SLCR_RDATA_UNMAPPED;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_rd_rsvd;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (take_w && i_avs_read && (idx_w == 4'h0 || idx_w == 4'hB)) |=> o_avs_readdata == 32'h0;
    endproperty
    a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved register read not zero");

    property p_path;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        1 |=> o_osc_path_enable == $past(r_path_w[0]);
    endproperty
    a_path: assert property (p_path) else $error("path enable mismatch"); // R10

    property p_ratio;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        1 |=> o_osc_out_divide_ratio == $past(r_path_w[2:1]);
    endproperty
    a_ratio: assert property (p_ratio) else $error("divide ratio mismatch"); // R9

    property p_force;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        1 |=> {o_pump_force_up, o_pump_force_down} == $past(r_det_w[2:1]);
    endproperty
    a_force: assert property (p_force) else $error("force bits mismatch"); // R7

    property p_term;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        1 |=> o_osc_driver_term_0 == $past(r_drv0_w[2:1]);
    endproperty
    a_term: assert property (p_term) else $error("driver 0 termination mismatch"); // R12

    property p_fb_hi;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (mp.we && idx_w == 4'h5) |=> ##1 o_loop2_feedback_divider[15:8] == $past(mp.wdata, 2);
    endproperty
    a_fb_hi: assert property (p_fb_hi) else $error("feedback high byte not updated"); // R4

    property p_drv1;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (mp.we && idx_w == 4'hA) |=> ##1
            {o_osc_driver_standard_1, o_osc_driver_term_1, o_osc_driver_enable_1}
            == {$past(mp.wdata[5:4], 2), $past(mp.wdata[2:0], 2)};
    endproperty
    a_drv1: assert property (p_drv1) else $error("driver 1 controls not updated"); // R11

endmodule : slcr_top

// File: shared/slcr_map.svh
/*
 * Register map of the second loop configuration bank: offsets, field
 * positions, reset values and timing counts.
 * Assumes inclusion by bare name from any file that needs the map.
 */
`ifndef SLCR_MAP_SVH
`define SLCR_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte address = 4 * index)
// ----------------------------------------------------------------------
`define SLCR_IDX_RSVD_A      8'h31
`define SLCR_IDX_DOUBLER     8'h32
`define SLCR_IDX_REF_LO      8'h33
`define SLCR_IDX_REF_HI      8'h34
`define SLCR_IDX_FB_LO       8'h35
`define SLCR_IDX_FB_HI       8'h36
`define SLCR_IDX_PUMP        8'h37
`define SLCR_IDX_DETECT      8'h38
`define SLCR_IDX_OSC_PATH    8'h39
`define SLCR_IDX_DRV0        8'h3A
`define SLCR_IDX_DRV1        8'h3B
`define SLCR_IDX_RSVD_B      8'h3C
`define SLCR_IDX_FIRST       8'h31
`define SLCR_NUM_REGS        12

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SLCR_DBL_BYPASS_BIT  0
`define SLCR_REF_HI_MSB      3
`define SLCR_PUMP_MSB        3
`define SLCR_DET_UP_EN_BIT   4
`define SLCR_DET_DN_EN_BIT   3
`define SLCR_DET_FUP_BIT     2
`define SLCR_DET_FDN_BIT     1
`define SLCR_DET_POL_BIT     0
`define SLCR_PATH_DIV_MSB    2
`define SLCR_PATH_DIV_LSB    1
`define SLCR_PATH_EN_BIT     0
`define SLCR_DRV_STD_MSB     5
`define SLCR_DRV_STD_LSB     4
`define SLCR_DRV_TERM_MSB    2
`define SLCR_DRV_TERM_LSB    1
`define SLCR_DRV_EN_BIT      0

// ----------------------------------------------------------------------
// Reset values and masks of writable bits
// ----------------------------------------------------------------------
`define SLCR_RESET_VALUE     8'h00
`define SLCR_MASK_FULL       8'hFF
`define SLCR_MASK_DOUBLER    8'h01
`define SLCR_MASK_NIBBLE     8'h0F
`define SLCR_MASK_DETECT     8'h1F
`define SLCR_MASK_OSC_PATH   8'h07
`define SLCR_MASK_DRV        8'h37
`define SLCR_MASK_RSVD       8'h00
`define SLCR_RDATA_UNMAPPED  32'h00000000

// ----------------------------------------------------------------------
// Timing: read data are ready one cycle after a request is taken
// ----------------------------------------------------------------------
`define SLCR_READ_LATENCY    1

`endif

// File: shared/slcr_pkg.sv
/*
 * Types of the second loop configuration bank.
 * Assumes slcr_map.svh for numeric constants.
 */
package slcr_pkg;

    // ------------------------------------------------------------------
    // Output divide ratio, driver standards and driver terminations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SLCR_DIV_1 = 2'b00,
        SLCR_DIV_2 = 2'b01,
        SLCR_DIV_4 = 2'b10,
        SLCR_DIV_8 = 2'b11
    } slcr_div_e;

    typedef enum logic [1:0] {
        SLCR_STD_CML    = 2'b00,
        SLCR_STD_LVPECL = 2'b01,
        SLCR_STD_LVDS   = 2'b10,
        SLCR_STD_CMOS   = 2'b11
    } slcr_std_e;

    typedef enum logic [1:0] {
        SLCR_TERM_OFF  = 2'b00,
        SLCR_TERM_100  = 2'b01,
        SLCR_TERM_RSVD = 2'b10,
        SLCR_TERM_50   = 2'b11
    } slcr_term_e;

    // ------------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SLCR_ST_IDLE = 2'b00,
        SLCR_ST_ACK  = 2'b01
    } slcr_state_e;

    typedef logic [7:0] slcr_byte_t;

endpackage : slcr_pkg

// File: shared/slcr_mem_if.sv
/*
 * Access port between the bus slave and the register storage.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ns
interface slcr_mem_if;
    logic       we;
    logic [3:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] mask;

    modport ctrl (output we, output idx, output wdata, input rdata, input mask);
    modport mem  (input we, input idx, input wdata, output rdata, output mask);
endinterface : slcr_mem_if

// File: src/slcr_regfile.sv
/*
 * Storage of the twelve 8-bit configuration registers, registered read
 * data, and write masks that keep reserved bits at zero.
 * Assumes a synchronous active-high reset and one clock.
 */
`timescale 1ns/1ns
`include "slcr_map.svh"
module slcr_regfile (
    // Clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_sys_rst,
    // Access port
    slcr_mem_if.mem                    mp,
    // Flat view of every register
    output logic [`SLCR_NUM_REGS*8-1:0] o_regs
);
    import slcr_pkg::*;

    // ------------------------------------------------------------------
    // Writable-bit mask per register index
    // ------------------------------------------------------------------
    function automatic slcr_byte_t mask_of(input logic [3:0] idx);
        slcr_byte_t m;
        m = `SLCR_MASK_RSVD;
        if (idx == 4'h1) m = `SLCR_MASK_DOUBLER;
        else if (idx == 4'h2 || idx == 4'h4 || idx == 4'h5) m = `SLCR_MASK_FULL;
        else if (idx == 4'h3 || idx == 4'h6) m = `SLCR_MASK_NIBBLE;
        else if (idx == 4'h7) m = `SLCR_MASK_DETECT;
        else if (idx == 4'h8) m = `SLCR_MASK_OSC_PATH;
        else if (idx == 4'h9 || idx == 4'hA) m = `SLCR_MASK_DRV;
        return m;
    endfunction : mask_of

    slcr_byte_t mem_q [`SLCR_NUM_REGS];
    slcr_byte_t rdata_q;

    assign mp.mask  = mask_of(mp.idx);
    assign mp.rdata = rdata_q;

    genvar g;
    generate
        for (g = 0; g < `SLCR_NUM_REGS; g++) begin : g_reg
            always_ff @(posedge i_ref_clk) begin
                if (i_sys_rst) begin
                    mem_q[g] <= `SLCR_RESET_VALUE;
                end else if (mp.we && mp.idx == 4'(g)) begin
                    mem_q[g] <= mp.wdata & mp.mask;
                end
            end
            assign o_regs[g*8 +: 8] = mem_q[g];
        end
    endgenerate

    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdata_q <= `SLCR_RESET_VALUE;
        end else if (mp.idx < 4'(`SLCR_NUM_REGS)) begin
            rdata_q <= mem_q[mp.idx];
        end else begin
            rdata_q <= `SLCR_RESET_VALUE;
        end
    end

endmodule : slcr_regfile

// File: sim/second_loop_config_regs_tb.sv
/*
 * Self-checking bench of the second loop configuration bank: bus reads
 * and writes, decoded control outputs, refused accesses and reset.
 * Assumes the slcr_top port list and the register map header.
 */
`timescale 1ns/1ns
`include "slcr_map.svh"
module second_loop_config_regs_tb;
    import slcr_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic        i_ref_clk, i_sys_rst, i_avs_read, i_avs_write;
    logic [7:0]  i_avs_address;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic [3:0]  i_avs_byteenable, o_pump_current_setting, o_osc_div_factor;
    logic        o_avs_waitrequest, o_doubler_bypass, o_detector_up_enable;
    logic        o_detector_down_enable, o_pump_force_up, o_pump_force_down;
    logic        o_detector_polarity, o_osc_path_enable;
    logic        o_osc_driver_enable_0, o_osc_driver_enable_1;
    logic [11:0] o_loop2_ref_divider;
    logic [15:0] o_loop2_feedback_divider;
    slcr_div_e   o_osc_out_divide_ratio;
    slcr_std_e   o_osc_driver_standard_0, o_osc_driver_standard_1;
    slcr_term_e  o_osc_driver_term_0, o_osc_driver_term_1;
    logic [7:0]  mdl [12];
    logic [7:0]  rd;
    int          n_mismatch, total_checks, cyc;
    const logic [7:0] msk [12] = '{8'h00, 8'h01, 8'hFF, 8'h0F, 8'hFF, 8'hFF,
                                   8'h0F, 8'h1F, 8'h07, 8'h37, 8'h37, 8'h00};

    slcr_top dut_u (.*);

    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic logic [7:0] addr_of(input int i);
        return 8'((`SLCR_IDX_FIRST + i) * 4);
    endfunction : addr_of

    function automatic logic [11:0] ref_exp();
        logic [11:0] v;
        v = {mdl[3][3:0], mdl[2]};
        return (v == 12'h000) ? 12'h001 : v;
    endfunction : ref_exp

    // One Avalon transfer; waitrequest must fall exactly one cycle after take
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [7:0] r);
        int          waits;
        logic [31:0] wd;
        waits = 0;
        wd = $urandom;
        wd[7:0] = d;
        i_avs_address <= a;
        i_avs_writedata <= wd;
        i_avs_byteenable <= be;
        i_avs_write <= wr;
        i_avs_read <= !wr;
        do begin
            @(posedge i_ref_clk);
            waits++;
        end while (o_avs_waitrequest !== 1'b0);
        wd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        chk("wait_cycles", waits, 2);
        if (!wr)
            chk("readdata_upper", wd[31:8], 0);
        r = wd[7:0];
        @(posedge i_ref_clk);
    endtask : bus

    task automatic wr_reg(input int i, input logic [7:0] d);
        logic [7:0] r;
        logic [7:0] v;
        v = d & msk[i];
        if (i == 7 && v[2] && v[1]) v[1] = 1'b0;
        bus(1'b1, addr_of(i), v, 4'hF, r);
        mdl[i] = v;
    endtask : wr_reg

    task automatic rd_all;
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, addr_of(i), 8'h00, 4'hF, rd);
            chk("readback", rd, mdl[i]);
        end
    endtask : rd_all

    task automatic chk_outs;
        @(negedge i_ref_clk);
        chk("doubler_bypass", o_doubler_bypass, mdl[1][0]);
        chk("ref_div", o_loop2_ref_divider, ref_exp());
        chk("fb_div", o_loop2_feedback_divider, {mdl[5], mdl[4]});
        chk("pump", o_pump_current_setting, mdl[6][3:0]);
        chk("det_up", o_detector_up_enable, mdl[7][4]);
        chk("det_dn", o_detector_down_enable, mdl[7][3]);
        chk("force_up", o_pump_force_up, mdl[7][2]);
        chk("force_dn", o_pump_force_down, mdl[7][1]);
        chk("polarity", o_detector_polarity, mdl[7][0]);
        chk("path_en", o_osc_path_enable, mdl[8][0]);
        chk("div_ratio", o_osc_out_divide_ratio, mdl[8][2:1]);
        chk("div_factor", o_osc_div_factor, 4'h1 << mdl[8][2:1]);
        chk("std0", o_osc_driver_standard_0, mdl[9][5:4]);
        chk("term0", o_osc_driver_term_0, mdl[9][2:1]);
        chk("en0", o_osc_driver_enable_0, mdl[9][0]);
        chk("std1", o_osc_driver_standard_1, mdl[10][5:4]);
        chk("term1", o_osc_driver_term_1, mdl[10][2:1]);
        chk("en1", o_osc_driver_enable_1, mdl[10][0]);
        @(posedge i_ref_clk);
    endtask : chk_outs

    // ------------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------------
    always @(posedge i_ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        i_sys_rst = 1'b1;
        i_avs_read = 1'b0;
        i_avs_write = 1'b0;
        i_avs_address = 8'h00;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hF;
        n_mismatch = 0;
        total_checks = 0;
        cyc = 0;
        void'($urandom(32'h178E));
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (12) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        chk_outs();
        rd_all();
        // Random traffic over the whole bank, reserved places included
        repeat (40) begin
            wr_reg($urandom_range(0, 11), 8'($urandom));
            chk_outs();
        end
        rd_all();
        // Reference divider boundaries: zero, one, maximum
        wr_reg(2, 8'h00);
        wr_reg(3, 8'hF0);
        chk_outs();
        wr_reg(2, 8'h01);
        chk_outs();
        wr_reg(2, 8'hFF);
        wr_reg(3, 8'hFF);
        chk_outs();
        // Every divide ratio, driver standard and termination code
        for (int c = 0; c < 4; c++) begin
            wr_reg(8, {5'h1F, 2'(c), 1'(c)});
            wr_reg(9, {2'b11, 2'(c), 1'b1, 2'(c), 1'(c)});
            wr_reg(10, {2'b11, 2'(3 - c), 1'b1, 2'(3 - c), 1'(~c)});
            chk_outs();
        end
        // Force up alone, then force down alone
        wr_reg(7, 8'hFF);
        chk_outs();
        wr_reg(7, 8'h0A);
        chk_outs();
        // Refused: byte lane 0 off, unmapped and misaligned addresses
        bus(1'b1, addr_of(1), ~mdl[1] & msk[1], 4'hE, rd);
        bus(1'b1, 8'h00, 8'hFF, 4'hF, rd);
        bus(1'b1, 8'hC9, 8'hFF, 4'hF, rd);
        bus(1'b0, 8'hC9, 8'h00, 4'hF, rd);
        chk("misaligned_read", rd, 0);
        bus(1'b0, 8'h00, 8'h00, 4'hF, rd);
        chk("unmapped_read", rd, 0);
        wr_reg(0, 8'hFF);
        wr_reg(11, 8'hFF);
        rd_all();
        chk_outs();
        // Reset in mid-run returns every register to zero
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
        foreach (mdl[i]) mdl[i] = 8'h00;
        chk_outs();
        rd_all();
        conclude();
    end
endmodule : second_loop_config_regs_tb
